/* rtl/timer2_pkg.sv */
/*
  Shared constants and types for the 16-bit reload/capture timer with split mode.
  Assumes a single 20 MHz clock, a plain register port and same-clock tick sources.
*/
package timer2_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CONTROL      = 4'h0;
  localparam logic [3:0] ADDR_MODE         = 4'h1;
  localparam logic [3:0] ADDR_MODE_ONE     = 4'h2;
  localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h3;
  localparam logic [3:0] ADDR_COUNT_LOW    = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h5;
  localparam logic [3:0] ADDR_RELOAD_LOW   = 4'h6;
  localparam logic [3:0] ADDR_RELOAD_HIGH  = 4'h7;

  // Control register fields
  localparam int CTL_HIGH_OVF   = 7;
  localparam int CTL_EXT_EVENT  = 6;
  localparam int CTL_RX_OR_LOVF = 5;
  localparam int CTL_TX_OR_LIE  = 4;
  localparam int CTL_FALL_EN    = 3;
  localparam int CTL_MAIN_RUN   = 2;
  localparam int CTL_COUNTER    = 1;

  // Mode register fields
  localparam int MOD_SPLIT      = 7;
  localparam int MOD_LOW_RUN    = 6;
  localparam int MOD_AUTO_STOP  = 5;
  localparam int MOD_RISE_EN    = 4;
  localparam int MOD_OPMODE_LSB = 0;

  // Mode register one fields
  localparam int MOD1_IRQ_BLOCK = 0;
  localparam int MOD1_MEANING   = 1;
  localparam int MOD1_TRIG_LSB  = 4;

  // Clock select register fields
  localparam int CKS_HIGH_LSB   = 0;
  localparam int CKS_LOW_LSB    = 4;

  // Pin vector: eight trigger sources plus the event-count pin
  localparam int COUNT_PIN_IDX  = 8;

  localparam logic [7:0]  BYTE_ALL_ONES = 8'hff;
  localparam logic [15:0] WORD_ALL_ONES = 16'hffff;
  localparam logic [7:0]  READ_IDLE     = 8'h00;

  typedef enum logic [1:0] {
    MODE_RELOAD_EXT_FLAG = 2'b00,
    MODE_RELOAD_EXT_TRIG = 2'b01,
    MODE_CAPTURE         = 2'b10,
    MODE_CAPTURE_ZERO    = 2'b11
  } op_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic irq;
    logic overflowEventOut;
    logic txBaudClk;
    logic rxBaudClk;
  } timer_out_t;

  typedef struct packed {
    logic [7:0] countLowByte;
    logic [7:0] countHighByte;
    logic [7:0] reloadCaptureLow;
    logic [7:0] reloadCaptureHigh;
    logic       highOverflowFlag;
    logic       externalEventFlag;
    logic       lowOverflowFlag;
    logic       lowOverflowIrqEnable;
    logic       rxBaudSelect;
    logic       txBaudSelect;
    logic       fallingEdgeEnable;
    logic       mainRunBit;
    logic       timerOrCounterSelect;
    logic       splitModeSelect;
    logic       lowRunBit;
    logic       lowRunAutoStop;
    logic       risingEdgeEnable;
    op_mode_t   opMode;
    logic       overflowIrqBlock;
    logic       bitMeaningSelector;
    logic [2:0] trigSel;
    logic [2:0] highClkSel;
    logic [1:0] lowClkSel;
    logic [8:0] pinSync1;
    logic [8:0] pinSync2;
    logic [8:0] pinSync3;
    logic [8:0] pinLevel;
    logic       trigPrev;
    logic       countPinPrev;
    logic [7:0] rdata;
    timer_out_t out;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage

/* rtl/timer2_core.sv */
/*
  Timer 2 core: 16-bit reload/capture timer that can split into two 8-bit up-counters.
  Assumes tick sources are one-cycle pulses on clk; trigger and count pins are asynchronous.
*/
// Summary of operation
// - Control bit picks internal ticks or pin events
// - Auto-reload mode one sets high overflow flag
// - Falling trigger edge sets external event flag
// - Trigger chosen from eight external sources
// - Rising trigger edge acts like falling edge
// - Sixteen-bit overflow drives overflow event output
// - Mode two reloads both bytes on overflow
// - Mode two also reloads on trigger edge when no baud select is active
// - External event flag, unblocked high overflow flag or enabled split low overflow flag raises the single interrupt request
// - Capture mode copies count into reload bytes
// - Auto-zero capture also clears the count
// - Split mode runs two independent 8-bit counters
// - Main run gates high, low run gates low
// - High wrap clears low run when auto-stop
// - Split wraps set high and low overflow flags
// - Split flags clear only by software
// - Split overflow event comes from low byte
// - Control bits 5..4 meaning follows selector
// - Baud selects feed serial baud clocks
module timer2_core
  import timer2_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // Register port
  input  wire bus_req_t   bus,
  output logic [7:0]      rdata,
  // Tick sources and asynchronous pins
  input  wire logic [7:0] tickSrc,
  input  wire logic [7:0] trigPins,
  input  wire logic       countPin,
  // Events and interrupt
  output timer_out_t      tmrOut
);

  state_t r_reg;
  state_t r_next;

  logic        selLevel;
  logic        fallEdge;
  logic        riseEdge;
  logic        extEdge;
  logic        countPinRise;
  logic        highTick;
  logic        lowTick;
  logic [15:0] count16;
  logic        wrap16;
  logic        step16;
  logic        hiStep;
  logic        hiWrap;
  logic        loStep;
  logic        loWrap;
  logic        baudActive;
  logic        countWrite;
  logic        reloadWrite;
  logic        controlWrite;

  function automatic logic isAllOnes(input logic [7:0] v);
    return v == BYTE_ALL_ONES;
  endfunction

  // Bus passed in so the continuous assigns below see every change of it
  function automatic logic hit(input bus_req_t b, input logic [3:0] a);
    return b.wr && b.addr == a;
  endfunction

  assign selLevel     = r_reg.pinLevel[r_reg.trigSel];
  assign fallEdge     = r_reg.trigPrev & ~selLevel;
  assign riseEdge     = ~r_reg.trigPrev & selLevel;
  assign extEdge      = (r_reg.fallingEdgeEnable & fallEdge)
                      | (r_reg.risingEdgeEnable & riseEdge);
  assign countPinRise = ~r_reg.countPinPrev & r_reg.pinLevel[COUNT_PIN_IDX];
  assign highTick     = r_reg.timerOrCounterSelect ? countPinRise
                                                   : tickSrc[r_reg.highClkSel];
  assign lowTick      = tickSrc[{1'b0, r_reg.lowClkSel}];
  assign count16      = {r_reg.countHighByte, r_reg.countLowByte};
  assign step16       = ~r_reg.splitModeSelect & r_reg.mainRunBit & highTick;
  assign wrap16       = step16 & (count16 == WORD_ALL_ONES);
  assign hiStep       = r_reg.splitModeSelect & r_reg.mainRunBit & highTick;
  assign hiWrap       = hiStep & isAllOnes(r_reg.countHighByte);
  assign loStep       = r_reg.splitModeSelect & r_reg.lowRunBit & lowTick;
  assign loWrap       = loStep & isAllOnes(r_reg.countLowByte);
  assign baudActive   = ~r_reg.bitMeaningSelector
                      & (r_reg.txBaudSelect | r_reg.rxBaudSelect);
  assign countWrite   = hit(bus, ADDR_COUNT_LOW) | hit(bus, ADDR_COUNT_HIGH);
  assign reloadWrite  = hit(bus, ADDR_RELOAD_LOW) | hit(bus, ADDR_RELOAD_HIGH);
  assign controlWrite = hit(bus, ADDR_CONTROL);

  always_comb
  begin
    logic setHigh;
    logic setExt;
    logic setLow;
    logic ovfPulse;
    setHigh  = 1'b0;
    setExt   = 1'b0;
    setLow   = 1'b0;
    ovfPulse = 1'b0;
    r_next   = r_reg;

    // Three-stage pin synchroniser, level accepted when stages two and three agree
    r_next.pinSync1     = {countPin, trigPins};
    r_next.pinSync2     = r_reg.pinSync1;
    r_next.pinSync3     = r_reg.pinSync2;
    r_next.pinLevel     = (~(r_reg.pinSync2 ^ r_reg.pinSync3) & r_reg.pinSync3)
                        | ((r_reg.pinSync2 ^ r_reg.pinSync3) & r_reg.pinLevel);
    r_next.trigPrev     = selLevel;
    r_next.countPinPrev = r_reg.pinLevel[COUNT_PIN_IDX];

    if (!r_reg.splitModeSelect)
    begin
      if (step16)
      begin
        if (wrap16)
        begin
          setHigh  = 1'b1;
          ovfPulse = 1'b1;
          if (r_reg.opMode == MODE_CAPTURE || r_reg.opMode == MODE_CAPTURE_ZERO)
          begin
            r_next.countHighByte = 8'h00;
            r_next.countLowByte  = 8'h00;
          end
          else
          begin
            r_next.countHighByte = r_reg.reloadCaptureHigh;
            r_next.countLowByte  = r_reg.reloadCaptureLow;
          end
        end
        else
        begin
          {r_next.countHighByte, r_next.countLowByte} = 16'(count16 + 16'h0001);
        end
      end
      if (extEdge)
      begin
        setExt = 1'b1;
        unique case (r_reg.opMode)
          MODE_RELOAD_EXT_FLAG: ;
          MODE_RELOAD_EXT_TRIG:
          begin
            // A baud generator must keep its rate, so the trigger only flags
            if (!baudActive)
            begin
              r_next.countHighByte = r_reg.reloadCaptureHigh;
              r_next.countLowByte  = r_reg.reloadCaptureLow;
            end
          end
          MODE_CAPTURE:
          begin
            r_next.reloadCaptureHigh = r_reg.countHighByte;
            r_next.reloadCaptureLow  = r_reg.countLowByte;
          end
          MODE_CAPTURE_ZERO:
          begin
            r_next.reloadCaptureHigh = r_reg.countHighByte;
            r_next.reloadCaptureLow  = r_reg.countLowByte;
            r_next.countHighByte     = 8'h00;
            r_next.countLowByte      = 8'h00;
          end
        endcase
      end
    end
    else
    begin
      // Two independent byte counters
      if (hiStep)
      begin
        if (hiWrap)
        begin
          setHigh              = 1'b1;
          r_next.countHighByte = r_reg.reloadCaptureHigh;
        end
        else
        begin
          r_next.countHighByte = 8'(r_reg.countHighByte + 8'h01);
        end
      end
      if (loStep)
      begin
        if (loWrap)
        begin
          setLow              = 1'b1;
          ovfPulse            = 1'b1;
          r_next.countLowByte = r_reg.reloadCaptureLow;
        end
        else
        begin
          r_next.countLowByte = 8'(r_reg.countLowByte + 8'h01);
        end
      end
      if (extEdge)
      begin
        setExt = 1'b1;
      end
    end

    // Software writes override the counting in the same cycle
    if (bus.wr)
    begin
      unique case (bus.addr)
        ADDR_CONTROL:
        begin
          r_next.highOverflowFlag     = bus.wdata[CTL_HIGH_OVF];
          r_next.externalEventFlag    = bus.wdata[CTL_EXT_EVENT];
          if (r_reg.bitMeaningSelector)
          begin
            r_next.lowOverflowFlag      = bus.wdata[CTL_RX_OR_LOVF];
            r_next.lowOverflowIrqEnable = bus.wdata[CTL_TX_OR_LIE];
          end
          else
          begin
            r_next.rxBaudSelect = bus.wdata[CTL_RX_OR_LOVF];
            r_next.txBaudSelect = bus.wdata[CTL_TX_OR_LIE];
          end
          r_next.fallingEdgeEnable    = bus.wdata[CTL_FALL_EN];
          r_next.mainRunBit           = bus.wdata[CTL_MAIN_RUN];
          r_next.timerOrCounterSelect = bus.wdata[CTL_COUNTER];
        end
        ADDR_MODE:
        begin
          r_next.splitModeSelect  = bus.wdata[MOD_SPLIT];
          r_next.lowRunBit        = bus.wdata[MOD_LOW_RUN];
          r_next.lowRunAutoStop   = bus.wdata[MOD_AUTO_STOP];
          r_next.risingEdgeEnable = bus.wdata[MOD_RISE_EN];
          r_next.opMode           = op_mode_t'(bus.wdata[MOD_OPMODE_LSB +: 2]);
        end
        ADDR_MODE_ONE:
        begin
          r_next.overflowIrqBlock   = bus.wdata[MOD1_IRQ_BLOCK];
          r_next.bitMeaningSelector = bus.wdata[MOD1_MEANING];
          r_next.trigSel            = bus.wdata[MOD1_TRIG_LSB +: 3];
        end
        ADDR_CLOCK_SELECT:
        begin
          r_next.highClkSel = bus.wdata[CKS_HIGH_LSB +: 3];
          r_next.lowClkSel  = bus.wdata[CKS_LOW_LSB +: 2];
        end
        ADDR_COUNT_LOW:   r_next.countLowByte      = bus.wdata;
        ADDR_COUNT_HIGH:  r_next.countHighByte     = bus.wdata;
        ADDR_RELOAD_LOW:  r_next.reloadCaptureLow  = bus.wdata;
        ADDR_RELOAD_HIGH: r_next.reloadCaptureHigh = bus.wdata;
        default: ;
      endcase
    end

    // Hardware set wins over a software clear in the same cycle
    r_next.highOverflowFlag  = r_next.highOverflowFlag | setHigh;
    r_next.externalEventFlag = r_next.externalEventFlag | setExt;
    r_next.lowOverflowFlag   = r_next.lowOverflowFlag | setLow;
    if (hiWrap && r_reg.lowRunAutoStop)
    begin
      r_next.lowRunBit = 1'b0;
    end

    // Read data stand only in the cycle after the strobe
    r_next.rdata = READ_IDLE;
    if (bus.rd)
    begin
      unique case (bus.addr)
        ADDR_CONTROL:
          r_next.rdata = {r_reg.highOverflowFlag, r_reg.externalEventFlag,
                          r_reg.bitMeaningSelector ? r_reg.lowOverflowFlag
                                                   : r_reg.rxBaudSelect,
                          r_reg.bitMeaningSelector ? r_reg.lowOverflowIrqEnable
                                                   : r_reg.txBaudSelect,
                          r_reg.fallingEdgeEnable, r_reg.mainRunBit,
                          r_reg.timerOrCounterSelect, 1'b0};
        ADDR_MODE:
          r_next.rdata = {r_reg.splitModeSelect, r_reg.lowRunBit, r_reg.lowRunAutoStop,
                          r_reg.risingEdgeEnable, 2'b00, r_reg.opMode};
        ADDR_MODE_ONE:
          r_next.rdata = {1'b0, r_reg.trigSel, 2'b00, r_reg.bitMeaningSelector,
                          r_reg.overflowIrqBlock};
        ADDR_CLOCK_SELECT:
          r_next.rdata = {2'b00, r_reg.lowClkSel, 1'b0, r_reg.highClkSel};
        ADDR_COUNT_LOW:   r_next.rdata = r_reg.countLowByte;
        ADDR_COUNT_HIGH:  r_next.rdata = r_reg.countHighByte;
        ADDR_RELOAD_LOW:  r_next.rdata = r_reg.reloadCaptureLow;
        ADDR_RELOAD_HIGH: r_next.rdata = r_reg.reloadCaptureHigh;
        default:          r_next.rdata = READ_IDLE;
      endcase
    end

    // Registered so the request lines up with the flags it reflects
    r_next.out.irq = (r_next.highOverflowFlag & ~r_next.overflowIrqBlock)
                   | r_next.externalEventFlag
                   | (r_next.splitModeSelect & r_next.lowOverflowFlag
                      & r_next.lowOverflowIrqEnable);
    r_next.out.overflowEventOut = ovfPulse;
    r_next.out.txBaudClk = ovfPulse & ~r_reg.bitMeaningSelector & r_reg.txBaudSelect;
    r_next.out.rxBaudClk = ovfPulse & ~r_reg.bitMeaningSelector & r_reg.rxBaudSelect;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      r_reg <= STATE_RESET;
    else if (ce)
      r_reg <= r_next;
  end

  assign rdata  = r_reg.rdata;
  assign tmrOut = r_reg.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  high_ovf_set_a: assert property (
    ce && wrap16 |=> r_reg.highOverflowFlag && tmrOut.overflowEventOut)
    else $error("16-bit wrap did not set high overflow flag and event");

  wrap_reload_a: assert property (
    ce && wrap16 && !extEdge && !countWrite
    && (r_reg.opMode == MODE_RELOAD_EXT_FLAG || r_reg.opMode == MODE_RELOAD_EXT_TRIG)
    |=> {r_reg.countHighByte, r_reg.countLowByte}
        == $past({r_reg.reloadCaptureHigh, r_reg.reloadCaptureLow}))
    else $error("overflow did not reload the count");

  edge_reload_a: assert property (
    ce && !r_reg.splitModeSelect && extEdge && r_reg.opMode == MODE_RELOAD_EXT_TRIG
    && !baudActive && !countWrite
    |=> r_reg.countLowByte == $past(r_reg.reloadCaptureLow) && r_reg.externalEventFlag)
    else $error("trigger edge did not reload");

  fall_flag_a: assert property (
    ce && r_reg.fallingEdgeEnable && fallEdge |=> r_reg.externalEventFlag)
    else $error("falling trigger edge did not set event flag");

  rise_flag_a: assert property (
    ce && r_reg.risingEdgeEnable && riseEdge |=> r_reg.externalEventFlag)
    else $error("rising trigger edge did not set event flag");

  capture_copy_a: assert property (
    ce && !r_reg.splitModeSelect && extEdge && r_reg.opMode == MODE_CAPTURE && !reloadWrite
    |=> {r_reg.reloadCaptureHigh, r_reg.reloadCaptureLow} == $past(count16))
    else $error("capture did not copy the count");

  capture_zero_a: assert property (
    ce && !r_reg.splitModeSelect && extEdge && r_reg.opMode == MODE_CAPTURE_ZERO
    && !countWrite |=> {r_reg.countHighByte, r_reg.countLowByte} == 16'h0000)
    else $error("auto-zero capture did not clear count");

  irq_from_ext_a: assert property (
    ce && r_reg.externalEventFlag && !controlWrite |=> tmrOut.irq)
    else $error("event flag did not raise interrupt");

  auto_stop_a: assert property (
    ce && hiWrap && r_reg.lowRunAutoStop |=> !r_reg.lowRunBit)
    else $error("high byte wrap did not stop low counter");

  split_event_a: assert property (
    ce && r_reg.splitModeSelect |-> ##1 tmrOut.overflowEventOut == $past(loWrap))
    else $error("split overflow event not from low byte");

  low_gate_a: assert property (
    ce && r_reg.splitModeSelect && !r_reg.lowRunBit && !countWrite
    |=> r_reg.countLowByte == $past(r_reg.countLowByte))
    else $error("low byte counted while stopped");

  flag_hold_a: assert property (
    r_reg.splitModeSelect && r_reg.lowOverflowFlag && !controlWrite
    |=> r_reg.lowOverflowFlag)
    else $error("low overflow flag cleared without software");

endmodule // timer2_core

/* dv/timer2_reload_capture_split_bench.sv */
/*
  Self-checking bench for timer2_core: register port, tick pulses, trigger and count pins.
  Assumes the timer2_pkg register map; ce is held high except in t_freeze, tick sources are driven as pulses.
*/
module timer2_reload_capture_split_bench
  import timer2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 20000;

  logic       clk;
  logic       rstn;
  logic       ce;
  bus_req_t   bus;
  logic [7:0] rdata;
  logic [7:0] tickSrc;
  logic [7:0] trigPins;
  logic       countPin;
  timer_out_t tmrOut;
  int         errorCnt;
  int         nCompared;
  int         cycles;
  int         ovfCnt;
  int         txCnt;
  int         rxCnt;

  timer2_core uut (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .bus      (bus),
    .rdata    (rdata),
    .tickSrc  (tickSrc),
    .trigPins (trigPins),
    .countPin (countPin),
    .tmrOut   (tmrOut)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict();
    if (errorCnt == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Pulse counters; a pulse lasts one cycle so edge sampling sees each once
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    ovfCnt = ovfCnt + int'(tmrOut.overflowEventOut === 1'b1);
    txCnt  = txCnt + int'(tmrOut.txBaudClk === 1'b1);
    rxCnt  = rxCnt + int'(tmrOut.rxBaudClk === 1'b1);
    if (cycles == LIMIT)
    begin
      errorCnt = errorCnt + 1;
      $display("mismatch timeout expected %0d seen %0d", LIMIT - 1, cycles);
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    nCompared = nCompared + 1;
    if (seen !== exp)
    begin
      errorCnt = errorCnt + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic chkReg(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rdReg(a, d);
    chk($sformatf("reg%0h", a), 16'(exp), 16'(d));
  endtask

  task automatic chkCount(input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    rdReg(ADDR_COUNT_LOW, lo);
    rdReg(ADDR_COUNT_HIGH, hi);
    chk("count", exp, {hi, lo});
  endtask

  task automatic tick(input int idx);
    @(posedge clk);
    tickSrc[idx] <= 1'b1;
    @(posedge clk);
    tickSrc <= 8'h00;
  endtask

  // Pins are asynchronous: hold each level well past the synchroniser depth
  task automatic pin(input int k, input logic v);
    @(posedge clk);
    trigPins[k] <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic t_reset();
    for (int a = 0; a < 16; a++)
      chkReg(4'(a), 8'h00);
    wr(4'h9, 8'h5a);
    chkReg(4'h9, 8'h00);
  endtask

  task automatic t_reload16();
    int o;
    o = ovfCnt;
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_CLOCK_SELECT, 8'h03);
    wr(ADDR_CONTROL, 8'h14);
    tick(3);
    chkCount(16'hffff);
    tick(3);
    chkCount(16'h1234);
    chkReg(ADDR_CONTROL, 8'h94);
    chk("irq", 16'h1, 16'(tmrOut.irq));
    chk("ovfEvents", 16'h1, 16'(ovfCnt - o));
    chk("txBaud", 16'h1, 16'(txCnt));
    chk("rxBaud", 16'h0, 16'(rxCnt));
    wr(ADDR_MODE_ONE, 8'h01);
    repeat (2) @(posedge clk);
    chk("irqBlocked", 16'h0, 16'(tmrOut.irq));
    wr(ADDR_CONTROL, 8'h30);
    wr(ADDR_MODE_ONE, 8'h00);
    chkReg(ADDR_CONTROL, 8'h30);
    wr(ADDR_MODE_ONE, 8'h02);
    chkReg(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    chkReg(ADDR_CONTROL, 8'h10);
    wr(ADDR_MODE_ONE, 8'h00);
    chkReg(ADDR_CONTROL, 8'h30);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE_ONE, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE_ONE, 8'h00);
  endtask

  task automatic t_trig();
    wr(ADDR_CONTROL, 8'h08);
    for (int k = 0; k < 8; k++)
    begin
      wr(ADDR_MODE_ONE, {1'b0, 3'(k), 4'h0});
      repeat (8) @(posedge clk);
      // Switching source may leave one stray edge behind
      wr(ADDR_CONTROL, 8'h08);
      pin(k, 1'b0);
      chkReg(ADDR_CONTROL, 8'h48);
      chk("irqExt", 16'h1, 16'(tmrOut.irq));
      wr(ADDR_CONTROL, 8'h08);
      pin(k, 1'b1);
      chkReg(ADDR_CONTROL, 8'h08);
    end
    wr(ADDR_MODE, 8'h10);
    wr(ADDR_CONTROL, 8'h00);
    pin(7, 1'b0);
    chkReg(ADDR_CONTROL, 8'h00);
    pin(7, 1'b1);
    chkReg(ADDR_CONTROL, 8'h40);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MODE_ONE, 8'h00);
    repeat (8) @(posedge clk);
    wr(ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_modes();
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h01);
    wr(ADDR_RELOAD_LOW, 8'hcd);
    wr(ADDR_RELOAD_HIGH, 8'hab);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CONTROL, 8'h08);
    pin(0, 1'b0);
    chkCount(16'habcd);
    chkReg(ADDR_CONTROL, 8'h48);
    pin(0, 1'b1);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_COUNT_LOW, 8'h3c);
    wr(ADDR_COUNT_HIGH, 8'h5a);
    wr(ADDR_CONTROL, 8'h08);
    pin(0, 1'b0);
    chkReg(ADDR_RELOAD_LOW, 8'h3c);
    chkReg(ADDR_RELOAD_HIGH, 8'h5a);
    chkCount(16'h5a3c);
    chkReg(ADDR_CONTROL, 8'h48);
    pin(0, 1'b1);
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_COUNT_LOW, 8'h77);
    wr(ADDR_COUNT_HIGH, 8'h66);
    wr(ADDR_CONTROL, 8'h08);
    pin(0, 1'b0);
    chkReg(ADDR_RELOAD_LOW, 8'h77);
    chkReg(ADDR_RELOAD_HIGH, 8'h66);
    chkCount(16'h0000);
    pin(0, 1'b1);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_split();
    int o;
    o = ovfCnt;
    wr(ADDR_MODE_ONE, 8'h02);
    wr(ADDR_CLOCK_SELECT, 8'h12);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_RELOAD_LOW, 8'h20);
    wr(ADDR_RELOAD_HIGH, 8'h10);
    wr(ADDR_MODE, 8'he0);
    wr(ADDR_CONTROL, 8'h10);
    tick(2);
    tick(1);
    tick(1);
    chkCount(16'hff20);
    chkReg(ADDR_CONTROL, 8'h30);
    chk("irqLow", 16'h1, 16'(tmrOut.irq));
    chk("lowEvents", 16'h1, 16'(ovfCnt - o));
    wr(ADDR_CONTROL, 8'h34);
    tick(2);
    chkCount(16'h1020);
    chkReg(ADDR_MODE, 8'ha0);
    chk("highEvents", 16'h1, 16'(ovfCnt - o));
    tick(1);
    chkCount(16'h1020);
    repeat (20) @(posedge clk);
    chkReg(ADDR_CONTROL, 8'hb4);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MODE_ONE, 8'h00);
  endtask

  task automatic t_counter();
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CLOCK_SELECT, 8'h00);
    wr(ADDR_CONTROL, 8'h06);
    tick(0);
    tick(0);
    repeat (3)
    begin
      @(posedge clk);
      countPin <= 1'b1;
      repeat (6) @(posedge clk);
      countPin <= 1'b0;
      repeat (6) @(posedge clk);
    end
    chkCount(16'h0003);
    wr(ADDR_CONTROL, 8'h00);
  endtask

  // Clock enable low must freeze ticks and writes; then a reset in mid-run
  task automatic t_freeze();
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CLOCK_SELECT, 8'h00);
    wr(ADDR_CONTROL, 8'h04);
    @(posedge clk);
    ce <= 1'b0;
    tick(0);
    wr(ADDR_COUNT_LOW, 8'h55);
    @(posedge clk);
    ce <= 1'b1;
    chkCount(16'h0000);
    tick(0);
    chkCount(16'h0001);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    chkReg(ADDR_CONTROL, 8'h00);
    chkCount(16'h0000);
    tick(0);
    chkCount(16'h0000);
  endtask

  initial
  begin
    errorCnt  = 0;
    nCompared = 0;
    cycles    = 0;
    ovfCnt    = 0;
    txCnt     = 0;
    rxCnt     = 0;
    rstn      = 1'b0;
    ce        = 1'b1;
    bus       = '0;
    tickSrc   = 8'h00;
    trigPins  = 8'hff;
    countPin  = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_reload16();
    t_trig();
    t_modes();
    t_split();
    t_counter();
    t_freeze();
    print_verdict();
  end
endmodule // timer2_reload_capture_split_bench
